// ### verilog/ftv_vote_unit.sv
/*
 * ftv_vote_unit: buffers one message per remote source and votes them at a
 * scheduled local time (middle value, routing, word majority, bit majority).
 * assumes: one free-running clock; receivers deliver toggle-marked messages;
 * the controller arms a vote with its mask, kind and time in one strobe.
 */
`timescale 1ns/1ps

// What this block does
// - event vote is middle value select
// - routing votes only the chosen source
// - routing drops source with error or accusation
// - empty routing set gives defined empty result
// - word vote outputs exact-match majority value
// - majority is over half of eligible inputs
// - no word majority flags invalid and no-majority
// - bit vote takes majority per payload bit
// - bit without majority votes one
// - one receive input per remote source
// - received messages synchronised to local clock
// - buffered messages voted at scheduled local time
module ftv_vote_unit
	import ftv_pkg::*;
#(
	parameter int N = ftv_pkg::FTV_SOURCES,
	parameter int W = ftv_pkg::FTV_MSG_W,
	parameter int TW = ftv_pkg::FTV_TIME_W
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic [N-1:0] rx_toggle,
	input wire logic [N*W-1:0] rx_data,
	input wire logic [N-1:0] rx_err,
	input wire logic arm,
	input wire logic [N-1:0] elig_mask,
	input wire ftv_pkg::ftv_vote_t vote_kind,
	input wire logic [$clog2(N)-1:0] route_sel,
	input wire logic [N-1:0] accuse,
	input wire logic [TW-1:0] sched_time,
	output logic [W-1:0] vote_result,
	output logic result_valid,
	output logic no_majority,
	output logic route_empty,
	output logic vote_done,
	output logic busy,
	output logic [TW-1:0] local_time
);

	localparam int CW = $clog2(N + 1);
	localparam int SW = $clog2(N);
	localparam logic [CW-1:0] ONE = CW'(1);

	ftv_state_t state_q;
	ftv_vote_t kind_q;
	logic [N-1:0] mask_q;
	logic [SW-1:0] sel_q;
	logic [TW-1:0] sched_q;
	logic [TW-1:0] time_q;

	logic [N-1:0] in_valid;
	logic [N-1:0] in_err;
	logic [W-1:0] in_data [N];
	logic [W-1:0] buf_q [N];
	logic [N-1:0] have_q;
	logic [N-1:0] err_q;

	logic [N-1:0] elig;
	logic [CW-1:0] n_elig;
	logic [CW-1:0] match_cnt [N];
	logic [CW-1:0] rank [N];
	logic [CW-1:0] mid;
	logic [W-1:0] mvs_val;
	logic [W-1:0] maj_val;
	logic maj_found;
	logic [W-1:0] bit_val;
	logic route_ok;
	logic fire;

	logic [W-1:0] result_q;
	logic valid_q;
	logic nomaj_q;
	logic empty_q;
	logic done_q;

	// one synchroniser per remote source
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_rx
			ftv_rx_sync #(.W(W)) u_sync (
				.clock(clock),
				.rst(rst),
				.ce(ce),
				.rx_toggle(rx_toggle[gi]),
				.rx_data(rx_data[gi*W +: W]),
				.rx_err(rx_err[gi]),
				.msg_valid(in_valid[gi]),
				.msg_data(in_data[gi]),
				.msg_err(in_err[gi])
			);
		end
	endgenerate

	// free-running local-time clock
	always_ff @(posedge clock) begin
		if (rst)
			time_q <= '0;
		else if (ce)
			time_q <= time_q + TW'(1);
	end

	assign fire = (state_q == ST_WAIT) && (time_q == sched_q);

	// schedule: arm latches mask, kind, source and time together
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= ST_IDLE;
			kind_q <= ftv_vote_t'(FTV_TYPE_RST);
			mask_q <= '0;
			sel_q <= '0;
			sched_q <= '0;
		end else if (ce) begin
			unique case (state_q)
				ST_IDLE: begin
					if (arm) begin
						kind_q <= vote_kind;
						mask_q <= elig_mask;
						sel_q <= route_sel;
						sched_q <= sched_time;
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (fire)
						state_q <= ST_VOTE;
				end
				ST_VOTE: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// message buffer; a message arriving while the vote consumes wins
	generate
		for (gi = 0; gi < N; gi++) begin : g_buf
			always_ff @(posedge clock) begin
				if (rst) begin
					buf_q[gi] <= '0;
					have_q[gi] <= 1'b0;
					err_q[gi] <= 1'b0;
				end else if (ce) begin
					if (in_valid[gi]) begin
						buf_q[gi] <= in_data[gi];
						err_q[gi] <= in_err[gi];
						have_q[gi] <= 1'b1;
					end else if (state_q == ST_VOTE) begin
						have_q[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// eligibility; routing keeps only a clean, unaccused chosen source
	assign route_ok = mask_q[sel_q] && have_q[sel_q] && !err_q[sel_q] && !accuse[sel_q];

	always_comb begin
		if (kind_q == VT_ROUTE) begin
			elig = '0;
			elig[sel_q] = route_ok;
		end else begin
			elig = mask_q & have_q;
		end
	end

	always_comb begin
		n_elig = '0;
		for (int j = 0; j < N; j++)
			if (elig[j])
				n_elig = n_elig + ONE;
	end

	// per source: equal partners and sort rank among eligible inputs
	generate
		for (gi = 0; gi < N; gi++) begin : g_cmp
			always_comb begin
				match_cnt[gi] = '0;
				rank[gi] = '0;
				for (int j = 0; j < N; j++) begin
					if (elig[j] && buf_q[j] == buf_q[gi])
						match_cnt[gi] = match_cnt[gi] + ONE;
					if (elig[j] && (buf_q[j] < buf_q[gi] || (buf_q[j] == buf_q[gi] && j < gi)))
						rank[gi] = rank[gi] + ONE;
				end
			end
		end
	endgenerate

	// even counts take the lower of the two middle elements
	assign mid = (n_elig == '0) ? '0 : CW'((n_elig - ONE) >> 1);

	always_comb begin
		mvs_val = '0;
		maj_val = '0;
		maj_found = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (elig[i] && rank[i] == mid)
				mvs_val = buf_q[i];
			if (elig[i] && {match_cnt[i], 1'b0} > {1'b0, n_elig}) begin
				maj_val = buf_q[i];
				maj_found = 1'b1;
			end
		end
	end

	// per bit: one unless zeros hold a strict majority
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic [CW-1:0] zeros;
			always_comb begin
				zeros = '0;
				for (int j = 0; j < N; j++)
					if (elig[j] && !buf_q[j][gi])
						zeros = zeros + ONE;
			end
			assign bit_val[gi] = !({zeros, 1'b0} > {1'b0, n_elig});
		end
	endgenerate

	// result registers, updated only in the vote cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			result_q <= '0;
			valid_q <= 1'b0;
			nomaj_q <= 1'b0;
			empty_q <= 1'b0;
		end else if (ce && state_q == ST_VOTE) begin
			nomaj_q <= 1'b0;
			empty_q <= 1'b0;
			unique case (kind_q)
				VT_EVENT: begin
					result_q <= mvs_val;
					valid_q <= (n_elig != '0);
				end
				VT_ROUTE: begin
					// empty set: zero word, invalid, flagged, never a stale value
					result_q <= route_ok ? mvs_val : '0;
					valid_q <= route_ok;
					empty_q <= !route_ok;
				end
				VT_WORD: begin
					result_q <= maj_found ? maj_val : '0;
					valid_q <= maj_found;
					nomaj_q <= !maj_found;
				end
				VT_BIT: begin
					result_q <= bit_val;
					valid_q <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			done_q <= 1'b0;
		else if (ce)
			done_q <= (state_q == ST_VOTE);
	end

	assign vote_result = result_q;
	assign result_valid = valid_q;
	assign no_majority = nomaj_q;
	assign route_empty = empty_q;
	assign vote_done = done_q;
	assign busy = state_q[0];
	assign local_time = time_q;

	// checks
	property p_evt_mid;
		@(posedge clock) disable iff (rst)
		(ce && state_q == ST_VOTE && kind_q == VT_EVENT && n_elig != '0)
			|=> (valid_q && result_q == $past(mvs_val));
	endproperty
	a_evt_mid: assert property (p_evt_mid) else $error("event vote not middle value");

	property p_route_pass;
		@(posedge clock) disable iff (rst)
		(ce && state_q == ST_VOTE && kind_q == VT_ROUTE && route_ok)
			|=> (valid_q && !empty_q && result_q == $past(buf_q[sel_q]));
	endproperty
	a_route_pass: assert property (p_route_pass) else $error("routed value wrong");

	property p_route_drop;
		@(posedge clock) disable iff (rst)
		(ce && state_q == ST_VOTE && kind_q == VT_ROUTE && (err_q[sel_q] || accuse[sel_q]))
			|=> (!valid_q && empty_q && result_q == '0);
	endproperty
	a_route_drop: assert property (p_route_drop) else $error("faulty source routed");

	property p_word_maj;
		@(posedge clock) disable iff (rst)
		(ce && state_q == ST_VOTE && kind_q == VT_WORD && maj_found)
			|=> (valid_q && !nomaj_q && result_q == $past(maj_val));
	endproperty
	a_word_maj: assert property (p_word_maj) else $error("word majority lost");

	property p_word_none;
		@(posedge clock) disable iff (rst)
		(ce && state_q == ST_VOTE && kind_q == VT_WORD && n_elig == '0)
			|=> (nomaj_q && !valid_q);
	endproperty
	a_word_none: assert property (p_word_none) else $error("empty word vote not flagged");

	property p_bit_empty;
		@(posedge clock) disable iff (rst)
		(ce && state_q == ST_VOTE && kind_q == VT_BIT && n_elig == '0)
			|=> (result_q == {W{1'b1}});
	endproperty
	a_bit_empty: assert property (p_bit_empty) else $error("tied bits not one");

	property p_on_time;
		@(posedge clock) disable iff (rst)
		(ce && state_q == ST_WAIT && time_q == sched_q) |=> (state_q == ST_VOTE);
	endproperty
	a_on_time: assert property (p_on_time) else $error("vote missed schedule");

	property p_not_early;
		@(posedge clock) disable iff (rst)
		(state_q == ST_WAIT && time_q != sched_q) |=> (state_q != ST_VOTE);
	endproperty
	a_not_early: assert property (p_not_early) else $error("vote before schedule");

	property p_done_pulse;
		@(posedge clock) disable iff (rst)
		(ce && done_q) |=> (!ce || !done_q) ##1 (!ce || !done_q);
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done held too long");

	property p_cov_word_none;
		@(posedge clock) disable iff (rst)
		ce && state_q == ST_VOTE && kind_q == VT_WORD && !maj_found && n_elig != '0;
	endproperty
	c_word_none: cover property (p_cov_word_none);

	property p_cov_evt_even;
		@(posedge clock) disable iff (rst)
		ce && state_q == ST_VOTE && kind_q == VT_EVENT && n_elig == CW'(2);
	endproperty
	c_evt_even: cover property (p_cov_evt_even);

	property p_cov_route_acc;
		@(posedge clock) disable iff (rst)
		ce && state_q == ST_VOTE && kind_q == VT_ROUTE && accuse[sel_q];
	endproperty
	c_route_acc: cover property (p_cov_route_acc);

	property p_cov_bit;
		@(posedge clock) disable iff (rst)
		ce && state_q == ST_VOTE && kind_q == VT_BIT && n_elig == CW'(N);
	endproperty
	c_bit: cover property (p_cov_bit);

endmodule : ftv_vote_unit

// ### verilog/ftv_pkg.sv
/*
 * ftv_pkg: shared constants and types of the fault tolerant vote unit.
 * assumes: included by every design file of the vote unit and by the link model and bench.
 */
package ftv_pkg;

	// default shape of one node's receive side
	localparam int FTV_SOURCES = 4;
	localparam int FTV_MSG_W = 16;
	localparam int FTV_TIME_W = 16;

	// reset values
	localparam logic FTV_TOGGLE_RST = 1'b0;
	localparam logic [1:0] FTV_TYPE_RST = 2'b00;

	// vote kinds selected by the controlling logic
	typedef enum logic [1:0] {
		VT_EVENT = 2'b00,
		VT_ROUTE = 2'b01,
		VT_WORD = 2'b10,
		VT_BIT = 2'b11
	} ftv_vote_t;

	// gray codes along idle, wait, vote
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_VOTE = 2'b11
	} ftv_state_t;

endpackage : ftv_pkg

// ### verilog/ftv_rx_sync.sv
/*
 * ftv_rx_sync: brings one receiver's message into the local oscillator domain.
 * assumes: the receiver flips rx_toggle once per message and holds rx_data and
 * rx_err steady until the next flip, at least three clocks later.
 */
`timescale 1ns/1ps

module ftv_rx_sync
	import ftv_pkg::*;
#(
	parameter int W = ftv_pkg::FTV_MSG_W
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic rx_toggle,
	input wire logic [W-1:0] rx_data,
	input wire logic rx_err,
	output logic msg_valid,
	output logic [W-1:0] msg_data,
	output logic msg_err
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	// two stages; meta_q feeds sync_q only
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= FTV_TOGGLE_RST;
			sync_q <= FTV_TOGGLE_RST;
			last_q <= FTV_TOGGLE_RST;
		end else if (ce) begin
			meta_q <= rx_toggle;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// data is quiet by the time the toggle has crossed, so sampling it is safe
	always_ff @(posedge clock) begin
		if (rst) begin
			msg_valid <= 1'b0;
			msg_data <= '0;
			msg_err <= 1'b0;
		end else if (ce) begin
			msg_valid <= sync_q ^ last_q;
			if (sync_q ^ last_q) begin
				msg_data <= rx_data;
				msg_err <= rx_err;
			end
		end
	end

	property p_sync_pulse;
		@(posedge clock) disable iff (rst)
		(ce && msg_valid) |=> (!ce || !msg_valid);
	endproperty
	a_sync_pulse: assert property (p_sync_pulse) else $error("message strobe longer than one cycle");

endmodule : ftv_rx_sync

// ### verification/ftv_link_model.sv
/*
 * ftv_link_model: the per-source link receivers in front of the vote unit.
 * assumes: one send pulse per message from the bench, sampled on the rising clock edge.
 */
`timescale 1ns/1ps

module ftv_link_model
	import ftv_pkg::*;
#(
	parameter int N = ftv_pkg::FTV_SOURCES,
	parameter int W = ftv_pkg::FTV_MSG_W,
	parameter int MIN_GAP = 3
) (
	input wire logic clock,
	input wire logic [N-1:0] send,
	input wire logic [N*W-1:0] send_data,
	input wire logic [N-1:0] send_err,
	output logic [N-1:0] rx_toggle,
	output logic [N*W-1:0] rx_data,
	output logic [N-1:0] rx_err
);
	int gap_q [N];

	initial begin
		rx_toggle = '0;
		rx_data = '0;
		rx_err = '0;
		for (int i = 0; i < N; i++) begin
			gap_q[i] = MIN_GAP;
		end
	end

	// one receiver per remote source; data held until the next flip
	always @(posedge clock) begin
		for (int i = 0; i < N; i++) begin
			if (gap_q[i] < MIN_GAP) begin
				gap_q[i] <= gap_q[i] + 1;
			end
			// requests too close together are lost, as on a real link
			if (send[i] && gap_q[i] >= MIN_GAP) begin
				rx_toggle[i] <= ~rx_toggle[i];
				rx_data[i*W +: W] <= send_data[i*W +: W];
				rx_err[i] <= send_err[i];
				gap_q[i] <= 0;
			end
		end
	end
endmodule : ftv_link_model

// ### verification/tb_top.sv
/*
 * tb_top: self-checking bench of the vote unit fed by the link model.
 * assumes: design package compiled first; one 25 MHz clock, inputs moved on falling edges.
 */
`timescale 1ns/1ps

module tb_top;
	import ftv_pkg::*;
	localparam int N = 4;
	localparam int W = 16;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic arm = 1'b0;
	logic [N-1:0] elig_mask = '0;
	logic [N-1:0] accuse = '0;
	logic [N-1:0] snd = '0;
	logic [N-1:0] snd_err = '0;
	logic [N*W-1:0] snd_data = '0;
	ftv_vote_t vote_kind = VT_EVENT;
	logic [1:0] route_sel = '0;
	logic [15:0] sched_time = '0;
	logic [N-1:0] rx_toggle, rx_err;
	logic [N*W-1:0] rx_data;
	logic [W-1:0] vote_result;
	logic result_valid, no_majority, route_empty, vote_done, busy;
	logic [15:0] local_time;
	int error_cnt = 0;
	int check_count = 0;

	always #20 clock = ~clock;

	ftv_link_model #(.N(N), .W(W), .MIN_GAP(3)) link (.clock(clock), .send(snd),
		.send_data(snd_data), .send_err(snd_err), .rx_toggle(rx_toggle),
		.rx_data(rx_data), .rx_err(rx_err));

	ftv_vote_unit #(.N(N), .W(W), .TW(16)) DUT (.clock(clock), .rst(rst), .ce(ce),
		.rx_toggle(rx_toggle), .rx_data(rx_data), .rx_err(rx_err), .arm(arm),
		.elig_mask(elig_mask), .vote_kind(vote_kind), .route_sel(route_sel),
		.accuse(accuse), .sched_time(sched_time), .vote_result(vote_result),
		.result_valid(result_valid), .no_majority(no_majority),
		.route_empty(route_empty), .vote_done(vote_done), .busy(busy),
		.local_time(local_time));

	task automatic give_verdict;
		if (error_cnt == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// held apart by more than the synchroniser depth so nothing merges
	task automatic send(input logic [N-1:0] which, input logic [N*W-1:0] d,
		input logic [N-1:0] e);
		@(negedge clock);
		snd = which;
		snd_data = d;
		snd_err = e;
		@(negedge clock);
		snd = '0;
		repeat (4) @(negedge clock);
	endtask : send

	// ef packs valid, no majority, route empty, busy
	task automatic vote(input logic [N-1:0] m, input ftv_vote_t k, input logic [1:0] s,
		input logic [N-1:0] acc, input logic [W-1:0] ev, input logic [3:0] ef);
		logic [15:0] t;
		@(negedge clock);
		elig_mask = m;
		vote_kind = k;
		route_sel = s;
		accuse = acc;
		t = local_time + 16'h0005;
		sched_time = t;
		arm = 1'b1;
		@(negedge clock);
		arm = 1'b0;
		check("busy", busy, 1'b1);
		for (int i = 0; i < 40 && vote_done !== 1'b1; i++) @(negedge clock);
		check("vote_done", vote_done, 1'b1);
		check("vote_time", local_time, t + 16'h0002);
		check("vote_result", vote_result, ev);
		check("flags", {result_valid, no_majority, route_empty, busy}, ef);
	endtask : vote

	task automatic t_reset;
		logic [15:0] t;
		check("flags_rst", {result_valid, no_majority, route_empty, busy}, 4'h0);
		check("done_rst", vote_done, 1'b0);
		check("result_rst", vote_result, 16'h0000);
		t = local_time;
		ce = 1'b0;
		repeat (3) @(negedge clock);
		check("time_frozen", local_time, t);
		ce = 1'b1;
		@(negedge clock);
		check("time_count", local_time, t + 16'h0001);
	endtask : t_reset

	task automatic t_event;
		send(4'hf, {16'h0028, 16'h000a, 16'h001e, 16'h0014}, 4'h0);
		vote(4'hf, VT_EVENT, 2'h0, 4'h0, 16'h0014, 4'h8);
		send(4'hf, {16'h0028, 16'h000a, 16'h001e, 16'h0014}, 4'h0);
		vote(4'hb, VT_EVENT, 2'h0, 4'h0, 16'h001e, 4'h8);
		send(4'h7, {16'h0000, 16'h0007, 16'h0009, 16'h0005}, 4'h0);
		vote(4'hf, VT_EVENT, 2'h0, 4'h0, 16'h0007, 4'h8);
		vote(4'hf, VT_EVENT, 2'h0, 4'h0, 16'h0000, 4'h0);
	endtask : t_event

	task automatic rv(input logic [1:0] s, input logic [N-1:0] m, input logic [N-1:0] acc,
		input logic [W-1:0] ev, input logic [3:0] ef);
		send(4'hf, {16'h00d4, 16'h00c3, 16'h00b2, 16'h00a1}, 4'h4);
		vote(m, VT_ROUTE, s, acc, ev, ef);
	endtask : rv

	task automatic t_route;
		rv(2'h1, 4'hf, 4'h0, 16'h00b2, 4'h8);
		rv(2'h2, 4'hf, 4'h0, 16'h0000, 4'h2);
		rv(2'h3, 4'hf, 4'h8, 16'h0000, 4'h2);
		rv(2'h0, 4'he, 4'h0, 16'h0000, 4'h2);
	endtask : t_route

	task automatic t_word;
		send(4'hf, {16'h0007, 16'h0009, 16'h0007, 16'h0007}, 4'h0);
		vote(4'hf, VT_WORD, 2'h0, 4'h0, 16'h0007, 4'h8);
		send(4'hf, {16'h0007, 16'h0009, 16'h0009, 16'h0007}, 4'h0);
		vote(4'hf, VT_WORD, 2'h0, 4'h0, 16'h0000, 4'h4);
		send(4'hf, {16'h0007, 16'h0009, 16'h0009, 16'h0007}, 4'h0);
		vote(4'h6, VT_WORD, 2'h0, 4'h0, 16'h0009, 4'h8);
	endtask : t_word

	task automatic t_bit;
		send(4'hf, {16'hffff, 16'h0000, 16'h0f0f, 16'h00ff}, 4'h0);
		vote(4'hf, VT_BIT, 2'h0, 4'h0, 16'h0fff, 4'h8);
		send(4'hf, {16'hffff, 16'h0000, 16'h0f0f, 16'h00ff}, 4'h0);
		vote(4'h7, VT_BIT, 2'h0, 4'h0, 16'h000f, 4'h8);
	endtask : t_bit

	initial begin
		repeat (8) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		t_reset();
		t_event();
		t_route();
		t_word();
		t_bit();
		give_verdict();
	end

	// thirteen votes of some eight clocks each; far more means a hang
	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		give_verdict();
	end
endmodule : tb_top
